// File: rtl/hwloop_setup_decode.sv
/*
 * Decode and execute of the hardware-loop setup instructions. Writes the
 * begin, final and iteration-count state of loop 0 or loop 1.
 * Assumes INSN_VALID marks one issued instruction per cycle, on SYS_CLK,
 * with PC and RS1_VALUE belonging to that instruction.
 */
// Overview of operation
// RULE_01: Long forms write one field each; short forms write all three, body follows.
// RULE_02: Stored begin and final addresses always have their two low bits zero.
// RULE_03: Register begin and final forms drop the two low bits of rs1.
// RULE_04: Setup instructions exist only when the extension parameter equals 1.
// RULE_05: Instruction bit 7 selects loop set 0 or 1.
// RULE_06: Long immediate forms use PC plus immediate times 4; register forms copy rs1. The iteration immediate form stores the 12-bit imm as count.
// RULE_07: Fully immediate short setup: begin PC+4, final PC+5-bit imm*4, count 12-bit imm.
// RULE_08: Register short setup: begin PC+4, final PC+12-bit imm*4, count rs1.
// RULE_09: Opcode 0101011, funct3 100, sub-function bits 11:8 choose the operation.
// RULE_10: Field layout: immediate 31:20, rs1 field 19:15, zero fields where required.
// RULE_11: Sub-functions 1000 to 1111 are illegal and modify no loop state.
`timescale 1ns/1ps
`include "hwloop_defs.svh"
module hwloop_setup_decode #(
   parameter int CUSTOM_EXTENSION_ENABLE_PARAM = 1,
   parameter int NUM_LOOPS = 2
) (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic INSN_VALID,
   input wire logic [31:0] INSN,
   input wire logic [31:0] PC,
   input wire logic [31:0] RS1_VALUE,
   output logic SETUP_HIT,
   output logic ILLEGAL_INSN,
   output logic [31:0] LOOP0_BEGIN,
   output logic [31:0] LOOP0_FINAL,
   output logic [31:0] LOOP0_COUNT,
   output logic [31:0] LOOP1_BEGIN,
   output logic [31:0] LOOP1_FINAL,
   output logic [31:0] LOOP1_COUNT
);
   import hwloop_pkg::*;

   // Field extraction
   wire [6:0] opcode = INSN[`HWL_OPC_HI:0];
   wire [2:0] funct3 = INSN[`HWL_F3_HI:`HWL_F3_LO];
   wire [3:0] subfn = INSN[`HWL_SUB_HI:`HWL_SUB_LO]; // see RULE_09
   wire loop_sel = INSN[`HWL_SEL_BIT]; // see RULE_05
   wire [4:0] rs1_field = INSN[`HWL_RS1_HI:`HWL_RS1_LO];
   wire [11:0] wide_unsigned_immediate = INSN[`HWL_IMM_HI:`HWL_IMM_LO]; // see RULE_10
   wire [4:0] narrow_unsigned_immediate = rs1_field; // see RULE_10
   wire enabled = (CUSTOM_EXTENSION_ENABLE_PARAM == 1); // see RULE_04

   // Group decode: without the extension nothing under this opcode is ours
   wire group_hit = INSN_VALID && enabled && (opcode == `HWL_OPCODE)
      && (funct3 == `HWL_FUNCT3); // see RULE_04, see RULE_09
   wire sub_known = (subfn[3] == 1'b0); // see RULE_11
   hwl_op_t op;
   assign op = hwl_op_t'(subfn);

   // Reserved field checks: a malformed long form is refused rather than guessed
   wire imm_zero = (wide_unsigned_immediate == 12'h000);
   wire rs1_zero = (rs1_field == 5'h00);
   logic fields_ok;
   always_comb begin
      fields_ok = 1'b1;
      unique case (op)
         OP_BEGIN_IMM, OP_FINAL_IMM, OP_ITER_IMM: fields_ok = rs1_zero; // see RULE_10
         OP_BEGIN_REG, OP_FINAL_REG, OP_ITER_REG: fields_ok = imm_zero; // see RULE_10
         OP_SHORT_IMM, OP_SHORT_REG: fields_ok = 1'b1;
         default: fields_ok = 1'b0;
      endcase
   end

   wire do_exec = group_hit && sub_known && fields_ok;
   assign SETUP_HIT = do_exec;
   assign ILLEGAL_INSN = group_hit && !do_exec; // see RULE_11

   // Address arithmetic: immediates are word offsets from the instruction address
   wire [31:0] wide_ofs = {18'h00000, wide_unsigned_immediate, 2'h0};
   wire [31:0] narrow_ofs = {25'h0000000, narrow_unsigned_immediate, 2'h0};
   wire [31:0] pc_wide = PC + wide_ofs; // see RULE_06
   wire [31:0] pc_narrow = PC + narrow_ofs; // see RULE_07
   wire [31:0] pc_next = PC + `HWL_NEXT_INSN; // see RULE_07, see RULE_08
   wire [31:0] rs1_aligned = {RS1_VALUE[31:2], 2'h0}; // see RULE_03
   wire [31:0] imm_count = {20'h00000, wide_unsigned_immediate};

   // Per-operation values and write enables
   logic wr_b, wr_f, wr_c;
   logic [31:0] val_b, val_f, val_c;
   always_comb begin
      wr_b = 1'b0;
      wr_f = 1'b0;
      wr_c = 1'b0;
      val_b = pc_next;
      val_f = pc_wide;
      val_c = imm_count;
      unique case (op)
         OP_BEGIN_IMM: begin
            wr_b = 1'b1;
            val_b = pc_wide; // see RULE_06
         end
         OP_BEGIN_REG: begin
            wr_b = 1'b1;
            val_b = rs1_aligned; // see RULE_03, see RULE_06
         end
         OP_FINAL_IMM: begin
            wr_f = 1'b1;
            val_f = pc_wide; // see RULE_06
         end
         OP_FINAL_REG: begin
            wr_f = 1'b1;
            val_f = rs1_aligned; // see RULE_03, see RULE_06
         end
         OP_ITER_IMM: begin
            wr_c = 1'b1;
            val_c = imm_count; // see RULE_06
         end
         OP_ITER_REG: begin
            wr_c = 1'b1;
            val_c = RS1_VALUE; // see RULE_06
         end
         OP_SHORT_IMM: begin
            // Body starts right after the setup, so its reach is limited
            {wr_b, wr_f, wr_c} = 3'h7; // see RULE_01
            val_b = pc_next;
            val_f = pc_narrow; // see RULE_07
            val_c = imm_count; // see RULE_07
         end
         OP_SHORT_REG: begin
            {wr_b, wr_f, wr_c} = 3'h7; // see RULE_01
            val_b = pc_next;
            val_f = pc_wide; // see RULE_08
            val_c = RS1_VALUE; // see RULE_08
         end
         default: begin
            {wr_b, wr_f, wr_c} = 3'h0; // see RULE_11
         end
      endcase
   end

   // One state set per loop, written only when selected
   logic [31:0] begin_q [NUM_LOOPS];
   logic [31:0] final_q [NUM_LOOPS];
   logic [31:0] count_q [NUM_LOOPS];
   genvar g;
   generate
      for (g = 0; g < NUM_LOOPS; g++) begin : g_loop
         wire sel = do_exec && (int'(loop_sel) == g); // see RULE_05
         hwloop_set u_set (
            .clk(SYS_CLK),
            .rst(SYS_RST),
            .wr_begin(sel && wr_b),
            .wr_final(sel && wr_f),
            .wr_count(sel && wr_c),
            .begin_val(val_b),
            .final_val(val_f),
            .count_val(val_c),
            .begin_addr(begin_q[g]),
            .final_addr(final_q[g]),
            .count(count_q[g])
         );
      end
   endgenerate

   // Loop state outputs come straight from the storage flip-flops
   assign LOOP0_BEGIN = begin_q[0];
   assign LOOP0_FINAL = final_q[0];
   assign LOOP0_COUNT = count_q[0];
   assign LOOP1_BEGIN = begin_q[1];
   assign LOOP1_FINAL = final_q[1];
   assign LOOP1_COUNT = count_q[1];
endmodule

// File: rtl/hwloop_defs.svh
/*
 * Constants for the hardware-loop setup decoder: encodings, field positions,
 * reset values.
 * Assumes a 32-bit instruction word and a 32-bit address space.
 */
`ifndef HWLOOP_DEFS_SVH
`define HWLOOP_DEFS_SVH

`define HWL_OPCODE 7'h2b
`define HWL_FUNCT3 3'h4
`define HWL_OPC_HI 6
`define HWL_F3_HI 14
`define HWL_F3_LO 12
`define HWL_SUB_HI 11
`define HWL_SUB_LO 8
`define HWL_SEL_BIT 7
`define HWL_RS1_HI 19
`define HWL_RS1_LO 15
`define HWL_IMM_HI 31
`define HWL_IMM_LO 20
`define HWL_ADDR_SHIFT 2
`define HWL_NEXT_INSN 32'h0000_0004
`define HWL_ADDR_RESET 32'h0000_0000
`define HWL_COUNT_RESET 32'h0000_0000

`endif

// File: rtl/hwloop_pkg.sv
/*
 * Types for the hardware-loop setup decoder.
 * Assumes the constants header is compiled alongside.
 */
package hwloop_pkg;
   typedef enum logic [3:0] {
      OP_BEGIN_IMM = 4'h0,
      OP_BEGIN_REG = 4'h1,
      OP_FINAL_IMM = 4'h2,
      OP_FINAL_REG = 4'h3,
      OP_ITER_IMM = 4'h4,
      OP_ITER_REG = 4'h5,
      OP_SHORT_IMM = 4'h6,
      OP_SHORT_REG = 4'h7
   } hwl_op_t;
endpackage

// File: rtl/hwloop_set.sv
/*
 * One loop's state set: begin address, final address, iteration count.
 * Assumes the decoder presents aligned addresses and one-cycle write strobes.
 */
`timescale 1ns/1ps
`include "hwloop_defs.svh"
module hwloop_set (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_begin,
   input wire logic wr_final,
   input wire logic wr_count,
   input wire logic [31:0] begin_val,
   input wire logic [31:0] final_val,
   input wire logic [31:0] count_val,
   output logic [31:0] begin_addr,
   output logic [31:0] final_addr,
   output logic [31:0] count
);
   logic [29:0] begin_r;
   logic [29:0] final_r;
   logic [31:0] count_r;
   // Full-width reset address, so the stored part is a deliberate slice
   localparam logic [31:0] addr_rst = `HWL_ADDR_RESET;

   // Only the upper 30 bits are stored, so the low two can never be set
   always_ff @(posedge clk) begin
      if (rst) begin
         begin_r <= addr_rst[31:2];
         final_r <= addr_rst[31:2];
         count_r <= `HWL_COUNT_RESET;
      end else begin
         if (wr_begin) begin_r <= begin_val[31:2]; // see RULE_02
         if (wr_final) final_r <= final_val[31:2]; // see RULE_02
         if (wr_count) count_r <= count_val;
      end
   end

   // Low address bits are hardwired to zero
   assign begin_addr = {begin_r, 2'h0}; // see RULE_02
   assign final_addr = {final_r, 2'h0}; // see RULE_02
   assign count = count_r;
endmodule

// File: bench/hwloop_setup_decode_sva.sv
/* Port checker for the loop setup decoder.
   Assumes it is bound to hwloop_setup_decode, one clock domain. */
`timescale 1ns/1ps
module hwloop_setup_decode_sva #(
   parameter int CUSTOM_EXTENSION_ENABLE_PARAM = 1,
   parameter int NUM_LOOPS = 2
) (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic INSN_VALID,
   input wire logic [31:0] INSN,
   input wire logic [31:0] PC,
   input wire logic [31:0] RS1_VALUE,
   input wire logic SETUP_HIT,
   input wire logic ILLEGAL_INSN,
   input wire logic [31:0] LOOP0_BEGIN,
   input wire logic [31:0] LOOP0_FINAL,
   input wire logic [31:0] LOOP0_COUNT,
   input wire logic [31:0] LOOP1_BEGIN,
   input wire logic [31:0] LOOP1_FINAL,
   input wire logic [31:0] LOOP1_COUNT
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   // Own decode; reserved fields must be zero in the long forms
   wire en = CUSTOM_EXTENSION_ENABLE_PARAM == 1;
   wire match = INSN_VALID && INSN[6:0] == 7'h2b && INSN[14:12] == 3'h4;
   wire [3:0] sub = INSN[11:8];
   wire sel = INSN[7];
   wire bad_fld = sub[2:1] != 2'h3 && (sub[0] ? INSN[31:20] != 12'h0 : INSN[19:15] != 5'h0);
   wire legal = !sub[3] && !bad_fld;
   wire [95:0] l0 = {LOOP0_BEGIN, LOOP0_FINAL, LOOP0_COUNT};
   wire [95:0] l1 = {LOOP1_BEGIN, LOOP1_FINAL, LOOP1_COUNT};
   property p_hit; match |-> SETUP_HIT == (en && legal); endproperty
   a_hit: assert property (p_hit) else $error("setup hit wrong");
   property p_ill; en && match && sub[3] |-> ILLEGAL_INSN && !SETUP_HIT; endproperty
   a_ill: assert property (p_ill) else $error("illegal not flagged");
   property p_off; !en |-> !SETUP_HIT; endproperty
   a_off: assert property (p_off) else $error("hit while disabled");
   property p_hold; !SETUP_HIT |=> $stable(l0) && $stable(l1); endproperty
   a_hold: assert property (p_hold) else $error("state changed without hit");
   property p_align; (LOOP0_BEGIN[1:0] | LOOP0_FINAL[1:0] | LOOP1_BEGIN[1:0] |
      LOOP1_FINAL[1:0]) == 2'h0; endproperty
   a_align: assert property (p_align) else $error("address low bits set");
   property p_sel; SETUP_HIT && !sel |=> $stable(l1); endproperty
   a_sel: assert property (p_sel) else $error("wrong loop written");
   property p_short; SETUP_HIT && sub[3:1] == 3'h3 |=> ($past(sel) ? LOOP1_BEGIN :
      LOOP0_BEGIN) == (($past(PC) + 32'h4) & 32'hffff_fffc); endproperty
   a_short: assert property (p_short) else $error("short begin wrong");
   property p_creg; SETUP_HIT && sub[2:0] inside {3'h5, 3'h7} |=>
      ($past(sel) ? LOOP1_COUNT : LOOP0_COUNT) == $past(RS1_VALUE); endproperty
   a_creg: assert property (p_creg) else $error("count not rs1");
   property p_breg; SETUP_HIT && sub == 4'h1 |=> ($past(sel) ? LOOP1_BEGIN :
      LOOP0_BEGIN) == ($past(RS1_VALUE) & 32'hffff_fffc); endproperty
   a_breg: assert property (p_breg) else $error("register begin wrong");
   property p_fld; en && match && bad_fld |-> ILLEGAL_INSN && !SETUP_HIT; endproperty
   a_fld: assert property (p_fld) else $error("reserved field not refused");
   property p_simm; SETUP_HIT && sub == 4'h6 |=> ($past(sel) ? LOOP1_FINAL :
      LOOP0_FINAL) == $past(PC) + {25'h0, $past(INSN[19:15]), 2'h0}; endproperty
   a_simm: assert property (p_simm) else $error("short final wrong");
   c_short: cover property (SETUP_HIT && sub == 4'h6);
   c_reg: cover property (SETUP_HIT && sub == 4'h7);
   c_ill: cover property (ILLEGAL_INSN);
endmodule
bind hwloop_setup_decode hwloop_setup_decode_sva #(
   .CUSTOM_EXTENSION_ENABLE_PARAM(CUSTOM_EXTENSION_ENABLE_PARAM), .NUM_LOOPS(NUM_LOOPS)
) hwloop_setup_decode_sva_i (.SYS_CLK, .SYS_RST, .INSN_VALID, .INSN, .PC, .RS1_VALUE,
   .SETUP_HIT, .ILLEGAL_INSN, .LOOP0_BEGIN, .LOOP0_FINAL, .LOOP0_COUNT, .LOOP1_BEGIN,
   .LOOP1_FINAL, .LOOP1_COUNT);

// File: bench/tb_hwloop_setup_decode.sv
/* Self-checking bench for the loop setup decoder.
   Assumes the design files and the checker are compiled first. */
`timescale 1ns/1ps
module tb_hwloop_setup_decode;
   logic SYS_CLK = 1'b0, SYS_RST = 1'b1, INSN_VALID = 1'b0;
   logic [31:0] INSN = 32'h0, PC = 32'h0, RS1_VALUE = 32'h0;
   wire SETUP_HIT, ILLEGAL_INSN;
   wire [31:0] lb[2], lf[2], lc[2];
   logic [31:0] eb[2] = '{32'h0, 32'h0}, ef[2] = '{32'h0, 32'h0}, ec[2] = '{32'h0, 32'h0};
   int mismatches = 0, n_checks = 0;
   // Clock
   always #5 SYS_CLK = ~SYS_CLK;
   hwloop_setup_decode hwloop_setup_decode_i (.SYS_CLK, .SYS_RST, .INSN_VALID, .INSN, .PC,
      .RS1_VALUE, .SETUP_HIT, .ILLEGAL_INSN, .LOOP0_BEGIN(lb[0]), .LOOP0_FINAL(lf[0]),
      .LOOP0_COUNT(lc[0]), .LOOP1_BEGIN(lb[1]), .LOOP1_FINAL(lf[1]), .LOOP1_COUNT(lc[1]));
   wire off_hit, off_ill;
   wire [31:0] off_st[6];
   // Same stimulus into a build without the extension: it must ignore everything and flag nothing
   hwloop_setup_decode #(.CUSTOM_EXTENSION_ENABLE_PARAM(0)) hwloop_setup_decode_off_i (
      .SYS_CLK, .SYS_RST, .INSN_VALID, .INSN, .PC, .RS1_VALUE, .SETUP_HIT(off_hit),
      .ILLEGAL_INSN(off_ill), .LOOP0_BEGIN(off_st[0]), .LOOP0_FINAL(off_st[1]),
      .LOOP0_COUNT(off_st[2]), .LOOP1_BEGIN(off_st[3]), .LOOP1_FINAL(off_st[4]),
      .LOOP1_COUNT(off_st[5]));
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   // Both loop sets against the expected copies
   task automatic state();
      for (int l = 0; l < 2; l++) begin
         chk("begin", eb[l], lb[l]);
         chk("final", ef[l], lf[l]);
         chk("count", ec[l], lc[l]);
      end
      for (int k = 0; k < 6; k++) begin
         chk("off state", 32'h0, off_st[k]);
      end
   endtask
   // One instruction; the flags are combinational, so look once inputs settle
   task automatic issue(logic [3:0] f, logic l, logic [11:0] im, logic [4:0] r,
      logic [31:0] pc, logic [31:0] rs, logic hit);
      @(posedge SYS_CLK);
      INSN <= {im, r, 3'h4, f, l, 7'h2b};
      PC <= pc;
      RS1_VALUE <= rs;
      INSN_VALID <= 1'b1;
      #1 chk("hit", {31'h0, hit}, {31'h0, SETUP_HIT});
      chk("illegal", {31'h0, !hit}, {31'h0, ILLEGAL_INSN});
      chk("off hit", 32'h0, {31'h0, off_hit});
      chk("off illegal", 32'h0, {31'h0, off_ill});
      @(posedge SYS_CLK);
      INSN_VALID <= 1'b0;
      #1 state();
   endtask
   task automatic t_long();
      for (int l = 0; l < 2; l++) begin
         eb[l] = 32'h12ac;
         issue(4'h0, l[0], 12'h0ab, 5'h0, 32'h1000, 32'h0, 1'b1);
         eb[l] = 32'h8765_4320;
         issue(4'h1, l[0], 12'h0, 5'h3, 32'h0, 32'h8765_4323, 1'b1);
         ef[l] = 32'h5ffc;
         issue(4'h2, l[0], 12'hfff, 5'h0, 32'h2000, 32'h0, 1'b1);
         ef[l] = 32'h1234;
         issue(4'h3, l[0], 12'h0, 5'h4, 32'h0, 32'h1237, 1'b1);
         ec[l] = 32'hfff;
         issue(4'h4, l[0], 12'hfff, 5'h0, 32'h0, 32'h0, 1'b1);
         ec[l] = 32'hdead_beef;
         issue(4'h5, l[0], 12'h0, 5'h5, 32'h0, 32'hdead_beef, 1'b1);
      end
   endtask
   task automatic t_short();
      eb[1] = 32'h104; ef[1] = 32'h10c; ec[1] = 32'ha;
      issue(4'h6, 1'b1, 12'h00a, 5'h3, 32'h100, 32'h0, 1'b1);
      eb[0] = 32'h304; ef[0] = 32'h380; ec[0] = 32'h55;
      issue(4'h7, 1'b0, 12'h020, 5'h6, 32'h300, 32'h55, 1'b1);
   endtask
   // Refused encodings must leave every field alone
   task automatic t_ill();
      for (int f = 8; f < 16; f++) begin
         issue(f[3:0], 1'b0, 12'h1, 5'h1, 32'h40, 32'h7, 1'b0);
      end
      issue(4'h0, 1'b1, 12'h1, 5'h1, 32'h40, 32'h0, 1'b0);
      issue(4'h3, 1'b0, 12'h1, 5'h2, 32'h40, 32'h8, 1'b0);
   endtask
   // Two setups on consecutive edges must both land
   task automatic t_b2b();
      @(posedge SYS_CLK);
      INSN <= {12'h007, 5'h00, 3'h4, 4'h4, 1'b0, 7'h2b};
      INSN_VALID <= 1'b1;
      @(posedge SYS_CLK);
      INSN <= {12'h000, 5'h01, 3'h4, 4'h3, 1'b1, 7'h2b};
      RS1_VALUE <= 32'h0000_0a0b;
      @(posedge SYS_CLK);
      INSN_VALID <= 1'b0;
      ec[0] = 32'h0000_0007;
      ef[1] = 32'h0000_0a08;
      #1 state();
   endtask
   task automatic t_rst();
      @(posedge SYS_CLK);
      SYS_RST <= 1'b1;
      repeat (2) @(posedge SYS_CLK);
      SYS_RST <= 1'b0;
      eb = '{32'h0, 32'h0}; ef = '{32'h0, 32'h0}; ec = '{32'h0, 32'h0};
      #1 state();
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (8) @(posedge SYS_CLK);
      SYS_RST <= 1'b0;
      t_long();
      t_short();
      t_ill();
      t_b2b();
      t_rst();
      print_verdict();
   end
   // Watchdog; the whole run needs well under 200 cycles
   initial begin
      repeat (2000) @(posedge SYS_CLK);
      mismatches++;
      print_verdict();
   end
endmodule
